/* rtl/adc_ctrl_pkg.sv */
// constants shared by the conversion control block
package adc_ctrl_pkg;
    localparam int RESULT_W = 16;
    localparam int TOP_NIBBLE_LSB = 12;
    localparam int CONV_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int ACQ_TIME_NS = 250;
    localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 10;
    localparam int BIT_CNT_W = 5;
    localparam logic [4:0] BIT_CNT_RST = 5'h00;
    localparam logic [15:0] RESULT_RST = 16'h0000;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_ACQ = 3'b100
    } conv_state_t;
endpackage

/* rtl/result_store.sv */
// result register written at end of conversion, read data registered
`timescale 1ns/1ps
module result_store #(
    parameter int WIDTH = 16
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic wr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    output logic [WIDTH-1:0] rdata_o
);
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            rdata_o <= '0;
        end else if (wr_i) begin
            rdata_o <= wdata_i;
        end
    end
endmodule

/* rtl/sar_adc_conversion_control.sv */
// conversion sequencing and output port control of the sampling converter
//Contract
// - unfinished slave read at completion: drop, pulse flag
// - top four result bits driven whenever select and read low, serial mode included
// - busy high from start until result latched
// - output bus enabled only when select and read low
// - external serial clock gated by chip select
// - reset aborts conversion and clears logic
// - power down finishes conversion, then refuses starts
// - convert start falling edge holds and converts
// - low power mode with fast mode off: start held low restarts
// - reference disable high turns internal reference off
// - buffer disable high turns reference buffer off
// - result shifted out most significant bit first
`timescale 1ns/1ps
module sar_adc_conversion_control
    import adc_ctrl_pkg::*;
#(
    parameter int CONV_CNT = adc_ctrl_pkg::CONV_CYCLES,
    parameter int ACQ_CNT = adc_ctrl_pkg::ACQ_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic reset_in_i,
    input wire logic power_down_in_i,
    input wire logic convert_start_n_i,
    input wire logic low_power_mode_i,
    input wire logic fast_mode_i,
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    input wire logic serial_select_i,
    input wire logic external_clock_select_i,
    input wire logic ext_sclk_i,
    input wire logic internal_ref_disable_i,
    input wire logic ref_buffer_disable_i,
    input wire logic [adc_ctrl_pkg::RESULT_W-1:0] sample_code_i,
    output logic busy_o,
    output logic hold_o,
    output logic [adc_ctrl_pkg::RESULT_W-1:0] data_o,
    output logic [adc_ctrl_pkg::RESULT_W-1:0] data_oe_o,
    output logic serial_result_out_o,
    output logic incomplete_read_flag_o,
    output logic internal_ref_en_o,
    output logic ref_buffer_en_o,
    output logic low_power_o
);
    import adc_ctrl_pkg::*;

    // ------------------------------------------------------------
    // reset and start detection
    // ------------------------------------------------------------
    conv_state_t state_reg;
    logic clr;
    logic convert_start_n_d_reg;
    logic start_fall;
    logic [CNT_W-1:0] cnt_reg;
    logic conv_done;
    logic acq_done;
    logic [RESULT_W-1:0] result;
    logic [RESULT_W-1:0] shift_reg;
    logic [BIT_CNT_W-1:0] bit_cnt_reg;
    logic sclk_d_reg;
    logic sclk_rise;
    logic read_active;
    logic slave_serial;
    logic bus_en;
    logic start_now;

    assign clr = !rstn_i || reset_in_i;
    assign start_fall = convert_start_n_d_reg && !convert_start_n_i;
    assign conv_done = (state_reg == ST_CONV) && (cnt_reg == CNT_W'(CONV_CNT - 1));
    assign acq_done = (state_reg == ST_ACQ) && (cnt_reg == CNT_W'(ACQ_CNT - 1));
    assign slave_serial = serial_select_i && external_clock_select_i;
    assign bus_en = !cs_n_i && !rd_n_i;
    assign start_now = !power_down_in_i && ((state_reg == ST_IDLE && start_fall) ||
        (state_reg == ST_ACQ && (start_fall ||
         (acq_done && low_power_mode_i && !fast_mode_i && !convert_start_n_i))));

    always_ff @(posedge sys_clk_i) begin
        if (clr) begin
            convert_start_n_d_reg <= 1'b1;
        end else begin
            convert_start_n_d_reg <= convert_start_n_i;
        end
    end

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (clr) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    cnt_reg <= '0;
                    if (start_fall && !power_down_in_i) begin
                        state_reg <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    // start edges ignored here
                    if (conv_done) begin
                        cnt_reg <= '0;
                        state_reg <= ST_ACQ;
                    end else begin
                        cnt_reg <= cnt_reg + CNT_W'(1);
                    end
                end
                ST_ACQ: begin
                    if (power_down_in_i) begin
                        state_reg <= ST_IDLE;
                    end else if (start_now) begin
                        cnt_reg <= '0;
                        state_reg <= ST_CONV;
                    end else if (acq_done) begin
                        cnt_reg <= '0;
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg + CNT_W'(1);
                    end
                end
            endcase
        end
    end

    // busy and hold follow the sequencer state
    always_ff @(posedge sys_clk_i) begin
        if (clr) begin
            busy_o <= 1'b0;
            hold_o <= 1'b0;
        end else begin
            busy_o <= (state_reg == ST_CONV) ? !conv_done : start_now;
            hold_o <= (state_reg == ST_CONV) ? !conv_done : start_now;
        end
    end

    // ------------------------------------------------------------
    // result latch
    // ------------------------------------------------------------
    result_store #(
        .WIDTH(RESULT_W)
    ) u_store (
        .sys_clk_i(sys_clk_i),
        .rstn_i(!clr),
        .wr_i(conv_done),
        .wdata_i(sample_code_i),
        .rdata_o(result)
    );

    // ------------------------------------------------------------
    // serial shift register and incomplete read flag
    // ------------------------------------------------------------
    assign sclk_rise = ext_sclk_i && !sclk_d_reg && !cs_n_i;
    assign read_active = bit_cnt_reg != BIT_CNT_RST;

    always_ff @(posedge sys_clk_i) begin
        if (clr) begin
            sclk_d_reg <= 1'b0;
        end else begin
            sclk_d_reg <= ext_sclk_i;
        end
    end

    logic conv_done_d_reg;
    always_ff @(posedge sys_clk_i) begin
        if (clr) begin
            conv_done_d_reg <= 1'b0;
        end else begin
            conv_done_d_reg <= conv_done;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (clr) begin
            shift_reg <= RESULT_RST;
            bit_cnt_reg <= BIT_CNT_RST;
            incomplete_read_flag_o <= 1'b0;
        end else begin
            incomplete_read_flag_o <= 1'b0;
            if (conv_done_d_reg) begin
                shift_reg <= result;
                bit_cnt_reg <= BIT_CNT_RST;
                incomplete_read_flag_o <= slave_serial && read_active;
            end else if (slave_serial && sclk_rise && bus_en) begin
                shift_reg <= {shift_reg[RESULT_W-2:0], 1'b0};
                bit_cnt_reg <= (bit_cnt_reg == BIT_CNT_W'(RESULT_W - 1)) ? BIT_CNT_RST :
                    bit_cnt_reg + BIT_CNT_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // output bus
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (clr) begin
            data_o <= '0;
            data_oe_o <= '0;
            serial_result_out_o <= 1'b0;
        end else begin
            data_o <= result;
            serial_result_out_o <= shift_reg[RESULT_W-1];
            for (int i = 0; i < RESULT_W; i++) begin
                if (i >= TOP_NIBBLE_LSB) begin
                    data_oe_o[i] <= bus_en;
                end else begin
                    data_oe_o[i] <= bus_en && !serial_select_i;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // reference and power controls
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (clr) begin
            internal_ref_en_o <= 1'b0;
            ref_buffer_en_o <= 1'b0;
            low_power_o <= 1'b0;
        end else begin
            internal_ref_en_o <= !internal_ref_disable_i;
            ref_buffer_en_o <= !ref_buffer_disable_i;
            low_power_o <= power_down_in_i && (state_reg != ST_CONV);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    busy_start_a: assert property (@(posedge sys_clk_i) disable iff (clr)
        (state_reg == ST_IDLE && start_fall && !power_down_in_i) |=> busy_o)
        else $error("busy not raised on start");
    busy_hold_a: assert property (@(posedge sys_clk_i) disable iff (clr)
        $rose(busy_o) |-> busy_o [*8])
        else $error("busy dropped early");
    busy_end_a: assert property (@(posedge sys_clk_i) disable iff (clr)
        conv_done |=> !busy_o)
        else $error("busy not cleared at completion");
    pd_block_a: assert property (@(posedge sys_clk_i) disable iff (clr)
        (state_reg == ST_IDLE && power_down_in_i) |=> state_reg == ST_IDLE)
        else $error("conversion started in power down");
    busy_ignore_a: assert property (@(posedge sys_clk_i) disable iff (clr)
        (state_reg == ST_CONV && !conv_done) |=> state_reg == ST_CONV && cnt_reg != '0)
        else $error("conversion restarted");
    bus_gate_a: assert property (@(posedge sys_clk_i) disable iff (clr)
        !bus_en |=> data_oe_o == '0)
        else $error("bus driven without select and read");
    top_bits_a: assert property (@(posedge sys_clk_i) disable iff (clr)
        bus_en |=> data_oe_o[RESULT_W-1:TOP_NIBBLE_LSB] == 4'hf)
        else $error("top bits not driven");
    rd_err_a: assert property (@(posedge sys_clk_i) disable iff (clr)
        (conv_done_d_reg && slave_serial && read_active) |=> incomplete_read_flag_o)
        else $error("incomplete read not flagged");
    ref_sel_a: assert property (@(posedge sys_clk_i) disable iff (clr)
        internal_ref_disable_i |=> !internal_ref_en_o)
        else $error("internal reference left on");
    buf_sel_a: assert property (@(posedge sys_clk_i) disable iff (clr)
        ref_buffer_disable_i |=> !ref_buffer_en_o)
        else $error("reference buffer left on");
    auto_start_a: assert property (@(posedge sys_clk_i) disable iff (clr)
        (acq_done && !power_down_in_i && low_power_mode_i && !fast_mode_i &&
         !convert_start_n_i) |=> state_reg == ST_CONV)
        else $error("low power auto start missed");
    gate_clk_a: assert property (@(posedge sys_clk_i) disable iff (clr)
        (cs_n_i && !conv_done_d_reg) |=> $stable(shift_reg))
        else $error("clock not gated by select");
    hold_match_a: assert property (@(posedge sys_clk_i) disable iff (clr)
        hold_o == busy_o)
        else $error("hold and busy disagree");
    acq_start_a: assert property (@(posedge sys_clk_i) disable iff (clr)
        (state_reg == ST_ACQ && start_fall && !power_down_in_i) |=> state_reg == ST_CONV)
        else $error("start during acquisition missed");
    low_power_a: assert property (@(posedge sys_clk_i) disable iff (clr)
        (power_down_in_i && state_reg != ST_CONV) |=> low_power_o)
        else $error("low power not entered");
    ref_on_a: assert property (@(posedge sys_clk_i) disable iff (clr)
        !internal_ref_disable_i |=> internal_ref_en_o)
        else $error("internal reference left off");
    buf_on_a: assert property (@(posedge sys_clk_i) disable iff (clr)
        !ref_buffer_disable_i |=> ref_buffer_en_o)
        else $error("reference buffer left off");
    serial_mask_a: assert property (@(posedge sys_clk_i) disable iff (clr)
        (bus_en && serial_select_i) |=> data_oe_o[TOP_NIBBLE_LSB-1:0] == '0)
        else $error("low bits driven in serial mode");
    flag_pulse_a: assert property (@(posedge sys_clk_i) disable iff (clr)
        incomplete_read_flag_o |=> !incomplete_read_flag_o)
        else $error("incomplete read flag longer than one cycle");
    shift_load_a: assert property (@(posedge sys_clk_i) disable iff (clr)
        conv_done_d_reg |=> shift_reg == result)
        else $error("shift register not loaded with result");

    conv_c: cover property (@(posedge sys_clk_i) disable iff (clr) conv_done);
    auto_c: cover property (@(posedge sys_clk_i) disable iff (clr)
        acq_done && low_power_mode_i && !convert_start_n_i);
    err_c: cover property (@(posedge sys_clk_i) disable iff (clr) incomplete_read_flag_o);
    pd_c: cover property (@(posedge sys_clk_i) disable iff (clr)
        state_reg == ST_IDLE && power_down_in_i && start_fall);
    acq_start_c: cover property (@(posedge sys_clk_i) disable iff (clr)
        state_reg == ST_ACQ && start_fall && !power_down_in_i);
endmodule

/* verification/host_reader.sv */
// host controller model: chip select, read strobe and external serial clock
`timescale 1ns/1ps
module host_reader (
    input wire logic sys_clk_i,
    input wire logic serial_result_out_i,
    output logic cs_n_o,
    output logic rd_n_o,
    output logic ext_sclk_o
);
    initial begin
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        ext_sclk_o = 1'b0;
    end
    // select and read strobe change together, held for the whole access
    task automatic select(input logic cs_on, input logic rd_on);
        @(posedge sys_clk_i);
        #1;
        cs_n_o = ~cs_on;
        rd_n_o = ~rd_on;
    endtask
    // sample the data line, then a rising clock edge shifts the next bit
    task automatic shift(input int n, output logic [15:0] bits);
        bits = 16'h0000;
        for (int i = 0; i < n; i++) begin
            repeat (2) @(posedge sys_clk_i);
            #1;
            bits = {bits[14:0], serial_result_out_i};
            ext_sclk_o = 1'b1;
            repeat (2) @(posedge sys_clk_i);
            #1;
            ext_sclk_o = 1'b0;
        end
    endtask
endmodule

/* verification/sar_adc_conversion_control_bench.sv */
// self-checking bench for the conversion control block
`timescale 1ns/1ps
module sar_adc_conversion_control_bench;
    import adc_ctrl_pkg::*;
    localparam int CONV = 8;
    localparam int ACQ = 4;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic reset_in_i = 1'b0;
    logic power_down_in_i = 1'b0;
    logic convert_start_n_i = 1'b1;
    logic low_power_mode_i = 1'b0;
    logic fast_mode_i = 1'b0;
    logic serial_select_i = 1'b0;
    logic external_clock_select_i = 1'b1;
    logic internal_ref_disable_i = 1'b0;
    logic ref_buffer_disable_i = 1'b0;
    logic [15:0] sample_code_i = 16'h0000;
    logic cs_n, rd_n, ext_sclk, busy_o, hold_o, sout, flag, ref_en, buf_en, low_power_o;
    logic [15:0] data_o, data_oe_o;
    int fails = 0;
    int tests_run = 0;
    int flag_cnt = 0;
    always #2 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (flag === 1'b1) flag_cnt++;
    sar_adc_conversion_control #(.CONV_CNT(CONV), .ACQ_CNT(ACQ)) i_sar_adc_conversion_control (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .reset_in_i(reset_in_i),
        .power_down_in_i(power_down_in_i), .convert_start_n_i(convert_start_n_i),
        .low_power_mode_i(low_power_mode_i), .fast_mode_i(fast_mode_i), .cs_n_i(cs_n),
        .rd_n_i(rd_n),
        .serial_select_i(serial_select_i), .external_clock_select_i(external_clock_select_i),
        .ext_sclk_i(ext_sclk), .internal_ref_disable_i(internal_ref_disable_i),
        .ref_buffer_disable_i(ref_buffer_disable_i), .sample_code_i(sample_code_i),
        .busy_o(busy_o), .hold_o(hold_o), .data_o(data_o), .data_oe_o(data_oe_o),
        .serial_result_out_o(sout), .incomplete_read_flag_o(flag),
        .internal_ref_en_o(ref_en), .ref_buffer_en_o(buf_en), .low_power_o(low_power_o));
    host_reader i_host_reader (.sys_clk_i(sys_clk_i), .serial_result_out_i(sout),
        .cs_n_o(cs_n), .rd_n_o(rd_n), .ext_sclk_o(ext_sclk));
    function automatic logic [15:0] b(input logic v);
        return {15'h0000, v};
    endfunction
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wait_busy(input logic lvl, input int lim, output int cyc);
        cyc = 0;
        while (busy_o !== lvl) begin
            if (cyc >= lim) begin
                fails++;
                $display("mismatch at %0t: busy wait ran out", $time);
                report_and_stop();
            end
            step(1);
            cyc++;
        end
    endtask
    task automatic convert(input logic [15:0] code);
        sample_code_i = code;
        convert_start_n_i = 1'b0;
        step(1);
        convert_start_n_i = 1'b1;
    endtask
    initial begin
        logic [15:0] got;
        int cyc;
        step(8);
        rstn_i = 1'b1;
        step(2);
        for (int k = 0; k < 4; k++) begin
            internal_ref_disable_i = k[0];
            ref_buffer_disable_i = k[1];
            step(2);
            check(b(ref_en), b(~k[0]));
            check(b(buf_en), b(~k[1]));
        end
        $display("test references done");
        convert(16'hb3c5);
        wait_busy(1'b1, 3, cyc);
        check(b(hold_o), 16'h0001);
        step(1);
        convert(16'hb3c5);
        wait_busy(1'b0, CONV + 2, cyc);
        check(b(cyc >= CONV - 3 && cyc <= CONV - 1), 16'h0001);
        step(2);
        check(data_o, 16'hb3c5);
        i_host_reader.select(1'b1, 1'b1);
        step(2);
        check(data_oe_o, 16'hffff);
        i_host_reader.select(1'b1, 1'b0);
        step(2);
        check(data_oe_o, 16'h0000);
        i_host_reader.select(1'b0, 1'b1);
        step(2);
        check(data_oe_o, 16'h0000);
        serial_select_i = 1'b1;
        i_host_reader.select(1'b1, 1'b1);
        step(2);
        check(data_oe_o, 16'hf000);
        i_host_reader.select(1'b0, 1'b0);
        $display("test conversion and output enable done");
        i_host_reader.shift(4, got);
        i_host_reader.select(1'b1, 1'b1);
        i_host_reader.shift(16, got);
        check(got, 16'hb3c5);
        $display("test serial read done");
        convert(16'h5a0f);
        wait_busy(1'b1, 3, cyc);
        wait_busy(1'b0, CONV + 2, cyc);
        i_host_reader.shift(5, got);
        check(got, 16'h000b);
        flag_cnt = 0;
        convert(16'hc3e1);
        wait_busy(1'b1, 3, cyc);
        wait_busy(1'b0, CONV + 2, cyc);
        step(4);
        check(16'(flag_cnt), 16'h0001);
        i_host_reader.shift(16, got);
        check(got, 16'hc3e1);
        i_host_reader.select(1'b0, 1'b0);
        $display("test incomplete read done");
        convert(16'h0ff0);
        wait_busy(1'b1, 3, cyc);
        power_down_in_i = 1'b1;
        wait_busy(1'b0, CONV + 2, cyc);
        step(2);
        check(data_o, 16'h0ff0);
        check(b(low_power_o), 16'h0001);
        convert(16'h1111);
        step(CONV);
        check(b(busy_o), 16'h0000);
        power_down_in_i = 1'b0;
        step(ACQ + 2);
        $display("test power down done");
        convert(16'h7777);
        wait_busy(1'b1, 3, cyc);
        step(2);
        reset_in_i = 1'b1;
        step(2);
        check(b(busy_o), 16'h0000);
        check(data_o, 16'h0000);
        reset_in_i = 1'b0;
        step(CONV + 2);
        check(data_o, 16'h0000);
        $display("test reset abort done");
        low_power_mode_i = 1'b1;
        sample_code_i = 16'h2468;
        convert_start_n_i = 1'b0;
        wait_busy(1'b1, 3, cyc);
        wait_busy(1'b0, CONV + 2, cyc);
        wait_busy(1'b1, ACQ + 3, cyc);
        check(b(busy_o), 16'h0001);
        check(b(cyc == ACQ), 16'h0001);
        low_power_mode_i = 1'b0;
        wait_busy(1'b0, CONV + 2, cyc);
        step(ACQ + 4);
        check(b(busy_o), 16'h0000);
        convert_start_n_i = 1'b1;
        $display("test low power restart done");
        low_power_mode_i = 1'b1;
        fast_mode_i = 1'b1;
        step(1);
        convert_start_n_i = 1'b0;
        wait_busy(1'b1, 3, cyc);
        wait_busy(1'b0, CONV + 2, cyc);
        step(ACQ + 4);
        check(b(busy_o), 16'h0000);
        convert_start_n_i = 1'b1;
        step(1);
        convert(16'h3c3c);
        wait_busy(1'b0, CONV + 2, cyc);
        convert(16'h4d4d);
        check(b(busy_o), 16'h0001);
        wait_busy(1'b0, CONV + 2, cyc);
        step(2);
        check(data_o, 16'h4d4d);
        $display("test fast mode and back to back done");
        report_and_stop();
    end
endmodule
